// [dv/pin_world.sv]
// Purpose: Board around the pins.
// Assumes: Released pins read their external source.
// Notes: A driven pin wins over the external level.
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  // Bit lines
  input wire logic [7:0] bit_o,
  input wire logic [7:0] bit_oe_n,
  input wire logic [7:0] bit_ext,
  output logic [7:0] bit_in,
  // Output-only lines
  input wire logic [1:0] out_o,
  input wire logic [1:0] out_oe_n,
  input wire logic [1:0] out_ext,
  output logic [1:0] out_in,
  // Reset pin with board pull-up
  input wire logic rst_o,
  input wire logic rst_oe_n,
  output logic rst_in
);
  assign bit_in = (bit_o & ~bit_oe_n) | (bit_ext & bit_oe_n);
  assign out_in = (out_o & ~out_oe_n) | (out_ext & out_oe_n);
  assign rst_in = rst_oe_n | rst_o;
endmodule
`default_nettype wire

// [dv/port_pin_mux_chk.sv]
// Purpose: Port-level checks of the pin-sharing block.
// Assumes: One clock; checks sleep during reset.
// Notes: Bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module port_pin_mux_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pins
  input wire logic [1:0] bit_output_lines_in,
  input wire logic [1:0] bit_output_lines_o,
  input wire logic [1:0] bit_output_lines_oe_n,
  input wire logic [3:0] nibble_port_c_o,
  input wire logic [3:0] nibble_port_c_oe_n,
  input wire logic [3:0] nibble_port_d_o,
  input wire logic [3:0] nibble_port_d_oe_n,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_n,
  // Reset sources and detector
  input wire logic wdt_reset,
  input wire logic por_reset,
  input wire logic drop_reset,
  input wire logic drop_detect_enable_pin,
  input wire logic drop_detect_run,
  // Events and display
  input wire logic ext_irq_a,
  input wire logic [3:0] display_commons_en,
  input wire logic [2:0] display_segments_en,
  input wire logic [2:0] display_supply_pins_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic any_src = wdt_reset | por_reset | drop_reset;
  chk_rst_pin_low: assert property (any_src |=> !reset_pin_oe_n && !reset_pin_o)
    else $error("reset pin not pulled low");
  chk_rst_pin_free: assert property (!any_src && !rst |=> reset_pin_oe_n)
    else $error("reset pin held without cause");
  chk_drop_follow: assert property ($stable(drop_detect_enable_pin) [*4] |->
    drop_detect_run == drop_detect_enable_pin) else $error("detector run mismatch");
  chk_coms_duty: assert property (display_commons_en inside {4'h3, 4'h7, 4'hf})
    else $error("common set illegal");
  chk_supply_excl: assert property (display_segments_en ==
    ~{display_supply_pins_en[0], display_supply_pins_en[1], display_supply_pins_en[2]})
    else $error("segment and supply overlap");
  chk_nib_od: assert property (((~nibble_port_c_oe_n & nibble_port_c_o) |
    (~nibble_port_d_oe_n & nibble_port_d_o)) == 4'h0) else $error("nibble drives high");
  chk_out_od: assert property ((~bit_output_lines_oe_n & bit_output_lines_o) == 2'h0)
    else $error("output line drives high");
  chk_irq_edge: assert property (ext_irq_a |-> !$past(bit_output_lines_in[0], 3)
    ##1 !ext_irq_a) else $error("irq pulse wrong");
endmodule
bind port_pin_mux port_pin_mux_chk i_chk (.*);
`default_nettype wire

// [dv/port_pin_mux_tb.sv]
// Purpose: Self-checking bench of the pin-sharing block.
// Assumes: Board level 5a on bit lines, pull-ups elsewhere.
// Notes: Pins settle a few clocks after a write.
`timescale 1ns/1ps
`default_nettype none
module port_pin_mux_tb;
  logic core_clk, rst, reset_pin_in, reset_pin_o, reset_pin_oe_n, wdt_reset, por_reset;
  logic drop_reset, drop_detect_enable_pin, drop_detect_run, timer1_underflow, timer4_pwm;
  logic timer2_underflow, timer1_event, timer3_event, serial_data_out, serial_clk_in;
  logic serial_clk_out, serial_clk_drive, serial_data_in, ext_irq_a, ext_irq_b, wake_req;
  logic timer_b_io_pin_in, timer_b_io_pin_o, timer_b_io_pin_oe_n;
  logic [7:0] bit_port_lines_in, bit_port_lines_o, bit_port_lines_oe_n, pull_up_en;
  logic [7:0] analog_inputs_en;
  logic [1:0] bit_output_lines_in, bit_output_lines_o, bit_output_lines_oe_n;
  logic [3:0] nibble_port_a_in, nibble_port_a_o, nibble_port_a_oe_n, nibble_port_b_in;
  logic [3:0] nibble_port_b_o, nibble_port_b_oe_n, nibble_port_c_in, nibble_port_c_o;
  logic [3:0] nibble_port_c_oe_n, nibble_port_d_in, nibble_port_d_o, nibble_port_d_oe_n;
  logic [3:0] nibble_port_e_in, nibble_port_e_o, nibble_port_e_oe_n, display_commons_en;
  logic [2:0] display_segments_en, display_supply_pins_en;
  logic [3:0] coms [3] = '{4'h3, 4'h7, 4'hf};
  pinmux_pkg::axil_req_t bus_req;
  pinmux_pkg::axil_rsp_t bus_rsp;
  int failures, checked, cycles, irqs;
  port_pin_mux i_dut (.*);
  pin_world i_world (.bit_o(bit_port_lines_o), .bit_oe_n(bit_port_lines_oe_n),
    .bit_ext(8'h5a), .bit_in(bit_port_lines_in), .out_o(bit_output_lines_o),
    .out_oe_n(bit_output_lines_oe_n), .out_ext(2'h3), .out_in(bit_output_lines_in),
    .rst_o(reset_pin_o), .rst_oe_n(reset_pin_oe_n), .rst_in(reset_pin_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.awaddr <= a;
    bus_req.wdata <= d;
    bus_req.wstrb <= 4'hf;
    {bus_req.awvalid, bus_req.wvalid, bus_req.bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (bus_rsp.awready) bus_req.awvalid <= 1'b0;
      if (bus_rsp.wready) bus_req.wvalid <= 1'b0;
    end while (bus_rsp.bvalid !== 1'b1);
    bus_req.bready <= 1'b0;
    chk(bus_rsp.bresp, pinmux_pkg::RESP_OKAY);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    bus_req.araddr <= a;
    {bus_req.arvalid, bus_req.rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (bus_rsp.arready) bus_req.arvalid <= 1'b0;
    end while (bus_rsp.rvalid !== 1'b1);
    bus_req.rready <= 1'b0;
    chk(bus_rsp.rdata, e);
    chk(bus_rsp.rresp, r);
    @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (ext_irq_a === 1'b1) irqs++;
    if (cycles == 2000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {wdt_reset, por_reset, drop_reset, drop_detect_enable_pin, timer1_underflow} = '0;
    {timer2_underflow, timer4_pwm, serial_clk_out, serial_clk_drive} = '0;
    {serial_data_out, timer_b_io_pin_in} = 2'h3;
    {nibble_port_a_in, nibble_port_b_in, nibble_port_c_in, nibble_port_d_in} = '1;
    nibble_port_e_in = '1;
    bus_req = '0;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    chk(bit_port_lines_oe_n, 8'hff);
    chk(reset_pin_oe_n, 1'b0);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(pinmux_pkg::OFS_BIT_LATCH, 32'h3ff, pinmux_pkg::RESP_OKAY);
    rd(pinmux_pkg::OFS_NIB_LATCH, 32'hfffff, pinmux_pkg::RESP_OKAY);
    rd(8'h24, 32'h0, pinmux_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(pinmux_pkg::OFS_FUNC, 32'h21);
    wr(pinmux_pkg::OFS_BIT_STRUCT, 32'h3);
    wr(pinmux_pkg::OFS_BIT_LATCH, 32'h6f1);
    repeat (6) @(posedge core_clk);
    chk(bit_port_lines_oe_n, 8'hf0);
    chk(bit_port_lines_o[3:0], 4'h1);
    chk(bit_output_lines_oe_n, 2'h2);
    chk(serial_data_in, 1'b1);
    chk(irqs, 1);
    rd(pinmux_pkg::OFS_BIT_PINS, 32'h251, pinmux_pkg::RESP_OKAY);
    wr(pinmux_pkg::OFS_NIB_LATCH, 32'hff0ff);
    chk(nibble_port_c_oe_n, 4'h0);
    chk(analog_inputs_en, 8'hf0);
    wdt_reset <= 1'b1;
    @(posedge core_clk);
    wdt_reset <= 1'b0;
    @(posedge core_clk);
    chk(reset_pin_oe_n, 1'b0);
    drop_detect_enable_pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(drop_detect_run, 1'b1);
    $display("test pins done");
    for (int i = 0; i < 3; i++) begin
      wr(pinmux_pkg::OFS_FUNC, 32'(i) << 7);
      chk(display_commons_en, coms[i]);
    end
    wr(pinmux_pkg::OFS_FUNC, 32'ha10);
    chk(display_segments_en, 3'h2);
    chk(display_supply_pins_en, 3'h5);
    chk(timer_b_io_pin_o, 1'b1);
    chk(timer_b_io_pin_oe_n, 1'b0);
    timer4_pwm <= 1'b1;
    wr(pinmux_pkg::OFS_BIT_LATCH, 32'h2f1);
    chk(timer_b_io_pin_o, 1'b1);
    timer4_pwm <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(timer_b_io_pin_o, 1'b0);
    wr(pinmux_pkg::OFS_FUNC, 32'h4);
    chk(bit_port_lines_oe_n[7], 1'b0);
    timer1_underflow <= 1'b1;
    @(posedge core_clk);
    timer1_underflow <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(bit_port_lines_oe_n[7], 1'b1);
    wr(pinmux_pkg::OFS_WAKE, 32'h100);
    chk(wake_req, 1'b1);
    wr(pinmux_pkg::OFS_NIB_CFG, 32'h3f000);
    chk(pull_up_en, 8'h3f);
    $display("test sharing done");
    close_out();
  end
endmodule
`default_nettype wire

// [hdl/bit_sync2.sv]
// Purpose: Two-stage synchroniser for a vector of pin levels.
// Assumes: Bits are independent levels; no word coherence is needed.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ps
`default_nettype none
module bit_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t s_q;
  sync_st_t s_d;

  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule
`default_nettype wire

// [hdl/pin_drive.sv]
// Purpose: Output stage of a group of pins, open-drain or push-pull per pin.
// Assumes: Output enable is active low.
// Notes: Open-drain pulls low for a zero and releases the pin for a one.
`timescale 1ns/1ps
`default_nettype none
module pin_drive #(
  parameter int W = 1
) (
  // Requested level and structure
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] push_pull,
  // Pin drive
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_n
);
  assign pin_o = level;
  // A released one lets the pin act as an input
  assign pin_oe_n = ~push_pull & level;
endmodule
`default_nettype wire

// [hdl/pinmux_pkg.sv]
// Purpose: Shared constants, bus carriers and helpers of the port and pin-sharing block.
// Assumes: AXI4-Lite slave with 8-bit byte addresses and 32-bit data.
package pinmux_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_BIT_LATCH = 8'h00;
  localparam logic [7:0] OFS_BIT_STRUCT = 8'h04;
  localparam logic [7:0] OFS_BIT_PINS = 8'h08;
  localparam logic [7:0] OFS_NIB_LATCH = 8'h0c;
  localparam logic [7:0] OFS_NIB_PINS = 8'h10;
  localparam logic [7:0] OFS_NIB_CFG = 8'h14;
  localparam logic [7:0] OFS_WAKE = 8'h18;
  localparam logic [7:0] OFS_FUNC = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Reset values: latches at one, except the single-bit port latch at zero, so every open-drain pin starts released
  localparam logic [10:0] RST_BIT_LATCH = 11'h3ff;
  localparam logic [7:0] RST_BIT_STRUCT = 8'h00;
  localparam logic [19:0] RST_NIB_LATCH = 20'hfffff;
  localparam logic [19:0] RST_NIB_CFG = 20'h00000;
  localparam logic [9:0] RST_WAKE = 10'h000;
  localparam logic [11:0] RST_FUNC = 12'h000;

  // Field positions
  localparam int BIT_LATCH_PORTC = 10;
  localparam int NIB_CFG_PP_A = 0;
  localparam int NIB_CFG_PP_B = 4;
  localparam int NIB_CFG_PP_E = 8;
  localparam int NIB_CFG_PU_A = 12;
  localparam int NIB_CFG_PU_B = 16;
  localparam int WAKE_NIB_A = 0;
  localparam int WAKE_NIB_B = 4;
  localparam int WAKE_IRQ_A = 8;
  localparam int WAKE_IRQ_B = 9;
  localparam int FUNC_SERIAL = 0;
  localparam int FUNC_TMR_A = 1;
  localparam int FUNC_TMR_B = 3;
  localparam int FUNC_IRQ_A = 5;
  localparam int FUNC_IRQ_B = 6;
  localparam int FUNC_DUTY = 7;
  localparam int FUNC_SUPPLY = 9;
  localparam int STATUS_RST_PIN = 0;
  localparam int STATUS_DROP_EN = 1;
  localparam int STATUS_WAKE = 2;

  typedef enum logic [1:0] {TMR_A_PORT, TMR_A_EVENT, TMR_A_OUT_T1, TMR_A_OUT_T2} tmr_a_mode_t;
  typedef enum logic [1:0] {TMR_B_PORT, TMR_B_EVENT, TMR_B_PWM} tmr_b_mode_t;
  typedef enum logic [1:0] {DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} duty_t;

  localparam logic [3:0] COMS_HALF = 4'h3;
  localparam logic [3:0] COMS_THIRD = 4'h7;
  localparam logic [3:0] COMS_QUARTER = 4'hf;

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// [hdl/port_pin_mux.sv]
// Purpose: Port latches, output structures and pin sharing with serial, timer, irq,
//          analog and display functions, under AXI4-Lite control.
// Assumes: Peripheral signals (timers, serial) run on core_clk; pins are asynchronous.
// Notes: A register write reaches the pins one clock after the write response edge.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module port_pin_mux (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire pinmux_pkg::axil_req_t bus_req,
  output pinmux_pkg::axil_rsp_t bus_rsp,
  // Bit port lines, timer A shares line 7
  input wire logic [7:0] bit_port_lines_in,
  output logic [7:0] bit_port_lines_o,
  output logic [7:0] bit_port_lines_oe_n,
  // Output-only lines, shared with ext_irq_a and ext_irq_b
  input wire logic [1:0] bit_output_lines_in,
  output logic [1:0] bit_output_lines_o,
  output logic [1:0] bit_output_lines_oe_n,
  // Nibble ports
  input wire logic [3:0] nibble_port_a_in,
  output logic [3:0] nibble_port_a_o,
  output logic [3:0] nibble_port_a_oe_n,
  input wire logic [3:0] nibble_port_b_in,
  output logic [3:0] nibble_port_b_o,
  output logic [3:0] nibble_port_b_oe_n,
  input wire logic [3:0] nibble_port_c_in,
  output logic [3:0] nibble_port_c_o,
  output logic [3:0] nibble_port_c_oe_n,
  input wire logic [3:0] nibble_port_d_in,
  output logic [3:0] nibble_port_d_o,
  output logic [3:0] nibble_port_d_oe_n,
  input wire logic [3:0] nibble_port_e_in,
  output logic [3:0] nibble_port_e_o,
  output logic [3:0] nibble_port_e_oe_n,
  output logic [7:0] pull_up_en,
  output logic [7:0] analog_inputs_en,
  // Single-bit port shared with timer B
  input wire logic timer_b_io_pin_in,
  output logic timer_b_io_pin_o,
  output logic timer_b_io_pin_oe_n,
  // Reset pin and drop detector
  input wire logic reset_pin_in,
  output logic reset_pin_o,
  output logic reset_pin_oe_n,
  input wire logic wdt_reset,
  input wire logic por_reset,
  input wire logic drop_reset,
  input wire logic drop_detect_enable_pin,
  output logic drop_detect_run,
  // Timers
  input wire logic timer1_underflow,
  input wire logic timer2_underflow,
  input wire logic timer4_pwm,
  output logic timer1_event,
  output logic timer3_event,
  // Serial unit
  input wire logic serial_data_out,
  input wire logic serial_clk_out,
  input wire logic serial_clk_drive,
  output logic serial_data_in,
  output logic serial_clk_in,
  // Interrupt and wakeup
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic wake_req,
  // Display
  output logic [3:0] display_commons_en,
  output logic [2:0] display_segments_en,
  output logic [2:0] display_supply_pins_en
);
  typedef struct packed {
    // Bus slave
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Software registers
    logic [10:0] bit_latch;
    logic [7:0] bit_struct;
    logic [19:0] nib_latch;
    logic [19:0] nib_cfg;
    logic [9:0] wake;
    logic [11:0] func;
    // Pin and side outputs
    logic [9:0] bit_o;
    logic [9:0] bit_oe_n;
    logic [19:0] nib_o;
    logic [19:0] nib_oe_n;
    logic c_o;
    logic c_oe_n;
    logic rst_o;
    logic rst_oe_n;
    logic tmr_a_tog;
    logic [1:0] irq_prev;
    logic [1:0] irq_req;
    logic wake_req;
    logic t1_event;
    logic t3_event;
    logic ser_in;
    logic ser_clk_in;
    logic drop_run;
    logic [7:0] pull_en;
    logic [7:0] ana_en;
    logic [3:0] com_en;
    logic [2:0] seg_en;
    logic [2:0] sup_en;
  } st_t;

  st_t s_q;
  st_t s_d;

  logic [9:0] bit_sync;
  logic [19:0] nib_sync;
  logic c_sync;
  logic rst_pin_sync;
  logic drop_en_sync;
  logic [29:0] drv_level;
  logic [29:0] drv_pp;
  logic [29:0] drv_o;
  logic [29:0] drv_oe_n;
  logic ser_on;
  pinmux_pkg::tmr_a_mode_t tmr_a_mode;
  pinmux_pkg::tmr_b_mode_t tmr_b_mode;
  logic tmr_a_out;
  logic [2:0] sup_sel;

  // Every pin level is synchronised before anything reads it
  bit_sync2 #(.W(33)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({drop_detect_enable_pin, reset_pin_in, timer_b_io_pin_in,
               nibble_port_e_in, nibble_port_d_in, nibble_port_c_in,
               nibble_port_b_in, nibble_port_a_in,
               bit_output_lines_in, bit_port_lines_in}),
    .sync_out({drop_en_sync, rst_pin_sync, c_sync, nib_sync, bit_sync})
  );

  assign ser_on = s_q.func[pinmux_pkg::FUNC_SERIAL];
  assign tmr_a_mode = pinmux_pkg::tmr_a_mode_t'(s_q.func[pinmux_pkg::FUNC_TMR_A +: 2]);
  assign tmr_b_mode = pinmux_pkg::tmr_b_mode_t'(s_q.func[pinmux_pkg::FUNC_TMR_B +: 2]);
  assign tmr_a_out = (tmr_a_mode == pinmux_pkg::TMR_A_OUT_T1) ||
                     (tmr_a_mode == pinmux_pkg::TMR_A_OUT_T2);
  assign sup_sel = s_q.func[pinmux_pkg::FUNC_SUPPLY +: 3];

  // Bit lines 0-3 follow their latch and per-line structure
  assign drv_level[3:0] = s_q.bit_latch[3:0];
  assign drv_pp[3:0] = s_q.bit_struct[3:0];
  // Serial input line is released so the pin is readable
  assign drv_level[4] = ser_on ? 1'b1 : s_q.bit_latch[4];
  assign drv_pp[4] = ser_on ? 1'b0 : s_q.bit_struct[4];
  assign drv_level[5] = ser_on ? serial_data_out : s_q.bit_latch[5];
  assign drv_pp[5] = s_q.bit_struct[5];
  assign drv_level[6] = ser_on ? (serial_clk_drive ? serial_clk_out : 1'b1) : s_q.bit_latch[6];
  assign drv_pp[6] = (ser_on && !serial_clk_drive) ? 1'b0 : s_q.bit_struct[6];
  // Timer output takes the line; event input leaves the port as it is
  assign drv_level[7] = tmr_a_out ? s_q.tmr_a_tog : s_q.bit_latch[7];
  assign drv_pp[7] = s_q.bit_struct[7];
  // Output-only lines always open-drain, kept under irq use
  assign drv_level[9:8] = s_q.bit_latch[9:8];
  assign drv_pp[9:8] = 2'b00;
  // Nibble ports: A, B and E switchable, C and D fixed open-drain
  assign drv_level[29:10] = s_q.nib_latch;
  assign drv_pp[29:10] = {s_q.nib_cfg[pinmux_pkg::NIB_CFG_PP_E +: 4], 8'h00,
                          s_q.nib_cfg[pinmux_pkg::NIB_CFG_PP_B +: 4],
                          s_q.nib_cfg[pinmux_pkg::NIB_CFG_PP_A +: 4]};

  pin_drive #(.W(30)) u_drive (
    .level(drv_level),
    .push_pull(drv_pp),
    .pin_o(drv_o),
    .pin_oe_n(drv_oe_n)
  );

  always_comb begin
    logic [31:0] wv;
    logic [31:0] rd;
    logic [1:0] rr;
    wv = '0;
    rd = '0;
    rr = pinmux_pkg::RESP_OKAY;
    s_d = s_q;

    // Write address and data are taken in either order
    if (bus_req.awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = bus_req.awaddr;
    end
    if (bus_req.wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.w_data = bus_req.wdata;
      s_d.w_strb = bus_req.wstrb;
    end
    if (s_q.bvalid && bus_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_d.aw_got && s_d.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = pinmux_pkg::RESP_OKAY;
      case (pinmux_pkg::word_addr(s_d.aw_addr))
        pinmux_pkg::OFS_BIT_LATCH: begin
          wv = pinmux_pkg::wmerge(32'(s_q.bit_latch), s_d.w_data, s_d.w_strb);
          s_d.bit_latch = wv[10:0];
        end
        pinmux_pkg::OFS_BIT_STRUCT: begin
          wv = pinmux_pkg::wmerge(32'(s_q.bit_struct), s_d.w_data, s_d.w_strb);
          s_d.bit_struct = wv[7:0];
        end
        pinmux_pkg::OFS_NIB_LATCH: begin
          wv = pinmux_pkg::wmerge(32'(s_q.nib_latch), s_d.w_data, s_d.w_strb);
          s_d.nib_latch = wv[19:0];
        end
        pinmux_pkg::OFS_NIB_CFG: begin
          wv = pinmux_pkg::wmerge(32'(s_q.nib_cfg), s_d.w_data, s_d.w_strb);
          s_d.nib_cfg = wv[19:0];
        end
        pinmux_pkg::OFS_WAKE: begin
          wv = pinmux_pkg::wmerge(32'(s_q.wake), s_d.w_data, s_d.w_strb);
          s_d.wake = wv[9:0];
        end
        pinmux_pkg::OFS_FUNC: begin
          wv = pinmux_pkg::wmerge(32'(s_q.func), s_d.w_data, s_d.w_strb);
          s_d.func = wv[11:0];
        end
        // Read-only registers ignore the data but answer OKAY
        pinmux_pkg::OFS_BIT_PINS, pinmux_pkg::OFS_NIB_PINS, pinmux_pkg::OFS_STATUS: begin
        end
        default: begin
          s_d.bresp = pinmux_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // Read channel: pin registers return synchronised levels
    case (pinmux_pkg::word_addr(bus_req.araddr))
      pinmux_pkg::OFS_BIT_LATCH: rd[10:0] = s_q.bit_latch;
      pinmux_pkg::OFS_BIT_STRUCT: rd[7:0] = s_q.bit_struct;
      pinmux_pkg::OFS_BIT_PINS: rd[9:0] = bit_sync;
      pinmux_pkg::OFS_NIB_LATCH: rd[19:0] = s_q.nib_latch;
      pinmux_pkg::OFS_NIB_PINS: rd[19:0] = nib_sync;
      pinmux_pkg::OFS_NIB_CFG: rd[19:0] = s_q.nib_cfg;
      pinmux_pkg::OFS_WAKE: rd[9:0] = s_q.wake;
      pinmux_pkg::OFS_FUNC: rd[11:0] = s_q.func;
      pinmux_pkg::OFS_STATUS: begin
        rd[pinmux_pkg::STATUS_RST_PIN] = rst_pin_sync;
        rd[pinmux_pkg::STATUS_DROP_EN] = drop_en_sync;
        rd[pinmux_pkg::STATUS_WAKE] = s_q.wake_req;
      end
      default: rr = pinmux_pkg::RESP_SLVERR;
    endcase
    if (s_q.rvalid && bus_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (bus_req.arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rr;
    end
    s_d.arready = !s_d.rvalid;

    // Pin drivers
    s_d.bit_o = drv_o[9:0];
    s_d.bit_oe_n = drv_oe_n[9:0];
    s_d.nib_o = drv_o[29:10];
    s_d.nib_oe_n = drv_oe_n[29:10];

    // Timer A output halves the selected underflow rate
    if ((tmr_a_mode == pinmux_pkg::TMR_A_OUT_T1 && timer1_underflow) ||
        (tmr_a_mode == pinmux_pkg::TMR_A_OUT_T2 && timer2_underflow)) begin
      s_d.tmr_a_tog = !s_q.tmr_a_tog;
    end
    s_d.t1_event = (tmr_a_mode == pinmux_pkg::TMR_A_EVENT) && bit_sync[7];

    // Single-bit port and timer B share one push-pull pin
    s_d.t3_event = 1'b0;
    case (tmr_b_mode)
      pinmux_pkg::TMR_B_EVENT: begin
        s_d.c_o = 1'b0;
        s_d.c_oe_n = 1'b1;
        s_d.t3_event = c_sync;
      end
      pinmux_pkg::TMR_B_PWM: begin
        s_d.c_o = timer4_pwm | s_q.bit_latch[pinmux_pkg::BIT_LATCH_PORTC];
        s_d.c_oe_n = 1'b0;
      end
      default: begin
        s_d.c_o = s_q.bit_latch[pinmux_pkg::BIT_LATCH_PORTC];
        s_d.c_oe_n = 1'b0;
      end
    endcase

    // Serial receive paths
    s_d.ser_in = ser_on && bit_sync[4];
    s_d.ser_clk_in = ser_on && !serial_clk_drive && bit_sync[6];

    // Interrupt pins request on a falling level
    s_d.irq_prev = bit_sync[9:8];
    s_d.irq_req[0] = s_q.func[pinmux_pkg::FUNC_IRQ_A] && s_q.irq_prev[0] && !bit_sync[8];
    s_d.irq_req[1] = s_q.func[pinmux_pkg::FUNC_IRQ_B] && s_q.irq_prev[1] && !bit_sync[9];

    // Key-on wakeup: any enabled line held low
    s_d.wake_req = |(s_q.wake[pinmux_pkg::WAKE_NIB_A +: 4] & ~nib_sync[3:0]) ||
                   |(s_q.wake[pinmux_pkg::WAKE_NIB_B +: 4] & ~nib_sync[7:4]) ||
                   (s_q.wake[pinmux_pkg::WAKE_IRQ_A] && !bit_sync[8]) ||
                   (s_q.wake[pinmux_pkg::WAKE_IRQ_B] && !bit_sync[9]);
    s_d.pull_en = {s_q.nib_cfg[pinmux_pkg::NIB_CFG_PU_B +: 4],
                   s_q.nib_cfg[pinmux_pkg::NIB_CFG_PU_A +: 4]};
    // Converter sees a pin only while its open-drain latch releases it
    s_d.ana_en = s_q.nib_latch[15:8];

    // Reset pin open-drain low on any system reset source
    s_d.rst_o = 1'b0;
    s_d.rst_oe_n = !(wdt_reset || por_reset || drop_reset);
    s_d.drop_run = drop_en_sync;

    // Commons by duty
    case (pinmux_pkg::duty_t'(s_q.func[pinmux_pkg::FUNC_DUTY +: 2]))
      pinmux_pkg::DUTY_HALF: s_d.com_en = pinmux_pkg::COMS_HALF;
      pinmux_pkg::DUTY_THIRD: s_d.com_en = pinmux_pkg::COMS_THIRD;
      default: s_d.com_en = pinmux_pkg::COMS_QUARTER;
    endcase
    // Segment k or supply pin 2-k, never both
    s_d.seg_en = ~sup_sel;
    s_d.sup_en = {sup_sel[0], sup_sel[1], sup_sel[2]};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.bit_latch <= pinmux_pkg::RST_BIT_LATCH;
      s_q.bit_struct <= pinmux_pkg::RST_BIT_STRUCT;
      s_q.nib_latch <= pinmux_pkg::RST_NIB_LATCH;
      s_q.nib_cfg <= pinmux_pkg::RST_NIB_CFG;
      s_q.wake <= pinmux_pkg::RST_WAKE;
      s_q.func <= pinmux_pkg::RST_FUNC;
      s_q.bit_oe_n <= '1;
      s_q.nib_oe_n <= '1;
      s_q.c_oe_n <= 1'b0;
      s_q.rst_oe_n <= 1'b0;
      s_q.com_en <= pinmux_pkg::COMS_HALF;
      s_q.seg_en <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign bus_rsp.awready = s_q.awready;
  assign bus_rsp.wready = s_q.wready;
  assign bus_rsp.bvalid = s_q.bvalid;
  assign bus_rsp.bresp = s_q.bresp;
  assign bus_rsp.arready = s_q.arready;
  assign bus_rsp.rvalid = s_q.rvalid;
  assign bus_rsp.rdata = s_q.rdata;
  assign bus_rsp.rresp = s_q.rresp;
  assign bit_port_lines_o = s_q.bit_o[7:0];
  assign bit_port_lines_oe_n = s_q.bit_oe_n[7:0];
  assign bit_output_lines_o = s_q.bit_o[9:8];
  assign bit_output_lines_oe_n = s_q.bit_oe_n[9:8];
  assign nibble_port_a_o = s_q.nib_o[3:0];
  assign nibble_port_a_oe_n = s_q.nib_oe_n[3:0];
  assign nibble_port_b_o = s_q.nib_o[7:4];
  assign nibble_port_b_oe_n = s_q.nib_oe_n[7:4];
  assign nibble_port_c_o = s_q.nib_o[11:8];
  assign nibble_port_c_oe_n = s_q.nib_oe_n[11:8];
  assign nibble_port_d_o = s_q.nib_o[15:12];
  assign nibble_port_d_oe_n = s_q.nib_oe_n[15:12];
  assign nibble_port_e_o = s_q.nib_o[19:16];
  assign nibble_port_e_oe_n = s_q.nib_oe_n[19:16];
  assign pull_up_en = s_q.pull_en;
  assign analog_inputs_en = s_q.ana_en;
  assign timer_b_io_pin_o = s_q.c_o;
  assign timer_b_io_pin_oe_n = s_q.c_oe_n;
  assign reset_pin_o = s_q.rst_o;
  assign reset_pin_oe_n = s_q.rst_oe_n;
  assign drop_detect_run = s_q.drop_run;
  assign timer1_event = s_q.t1_event;
  assign timer3_event = s_q.t3_event;
  assign serial_data_in = s_q.ser_in;
  assign serial_clk_in = s_q.ser_clk_in;
  assign ext_irq_a = s_q.irq_req[0];
  assign ext_irq_b = s_q.irq_req[1];
  assign wake_req = s_q.wake_req;
  assign display_commons_en = s_q.com_en;
  assign display_segments_en = s_q.seg_en;
  assign display_supply_pins_en = s_q.sup_en;
endmodule
`default_nettype wire
